// ### verilog/pllrh_config.sv
// Behaviour
// R1 - reference-control bit 7 puts the eeprom status on the status pin, else the status-select choice drives it.
// R2 - reference-control bit 6 enables the crystal maintaining amplifier, cleared by default.
// R3 - reference-control bit 5 enables the reference doubler, cleared (bypassed) by default.
// R4 - while reference-control bit 4 is set the pll status readback register stops updating.
// R5 - with reference-control bit 3 clear the holdover controller sees the lock indicator pin as high.
// R6 - with reference-control bit 3 set the lock indicator comparator output tells whether the pll was locked.
// R7 - reference-control bit 1 hands holdover entry to the output-align pin and disables internal holdover.
// R8 - reference-control bit 0 enables holdover, cleared by default.
// R9 - zero-delay register bits 4:3 pick channel divider 0 to 3 as external zero-delay feedback, default 0.
// R10 - zero delay runs only when its enable bit is set, and a select bit chooses external over internal mode.
// R11 - unused bits read as zero and ignore writes, reference-control resets to 0x80 and the rest to zero.
`include "pllrh_regs.svh"
`default_nettype none

module pllrh_config
    import pllrh_pkg::*;
(
    input  wire logic                      clk_sys,
    input  wire logic                      rst,
    input  wire logic [`PLLRH_ADDR_W-1:0] regAddr,
    input  wire logic                      regWrEn,
    input  wire logic [7:0]                regWrData,
    input  wire logic                      regRdEn,
    output logic      [7:0]                regRdData,
    output logic                           regRdValid,
    input  wire logic                      statusEeprom,
    input  wire logic                      statusSelected,
    output logic                           statusPinOut,
    output logic                           xtalAmpEn,
    output logic                           refDoublerEn,
    input  wire logic [7:0]                pllStatusLive,
    input  wire logic                      lockIndicatorPin,
    input  wire logic                      outputAlignPin,
    output logic                           holdoverInternalEn,
    output logic                           holdoverExternalEn,
    output logic                           holdoverExternalEntry,
    output logic                           holdoverLockQualified,
    output logic                           zeroDelayInternalEn,
    output logic                           zeroDelayExternalEn,
    output logic      [1:0]                zeroDelayFbSel,
    output logic      [3:0]                zeroDelayFbOneHot
);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [7:0] applyMask(input logic [7:0] val, input logic [7:0] mask);
        applyMask = val & mask;
    endfunction

    function automatic logic [3:0] decodeFb(input logic [1:0] sel);
        decodeFb = 4'h1 << sel;
    endfunction

    // ----------------------------------------
    // configuration registers
    // ----------------------------------------
    pllrh_refctl_t refCtl_ff;
    pllrh_refctl_t nxt_refCtl;
    pllrh_zdctl_t  zdCtl_ff;
    pllrh_zdctl_t  nxt_zdCtl;

    always_comb
    begin
        nxt_refCtl = refCtl_ff;
        nxt_zdCtl  = zdCtl_ff;
        // unused bits are masked on the way in so they always read back as zero
        if (regWrEn && regAddr == `PLLRH_ADDR_REFCTL)
        begin
            nxt_refCtl = pllrh_refctl_t'(applyMask(regWrData, `PLLRH_REFCTL_MASK)); // R11
        end
        if (regWrEn && regAddr == `PLLRH_ADDR_ZDCTL)
        begin
            nxt_zdCtl = pllrh_zdctl_t'(applyMask(regWrData, `PLLRH_ZDCTL_MASK)); // R11
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            refCtl_ff <= pllrh_refctl_t'(`PLLRH_REFCTL_RST); // R11
            zdCtl_ff  <= pllrh_zdctl_t'(`PLLRH_ZDCTL_RST);   // R11
        end
        else
        begin
            refCtl_ff <= nxt_refCtl;
            zdCtl_ff  <= nxt_zdCtl;
        end
    end

    // ----------------------------------------
    // status snapshot
    // ----------------------------------------
    logic [7:0] statSnap_ff;
    logic [7:0] nxt_statSnap;

    always_comb
    begin
        nxt_statSnap = statSnap_ff;
        // frozen snapshot lets software read a coherent set of status bits
        if (!refCtl_ff.freezeStatus)
        begin
            nxt_statSnap = applyMask(pllStatusLive, `PLLRH_STAT_MASK); // R4
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            statSnap_ff <= `PLLRH_STAT_RST;
        end
        else
        begin
            statSnap_ff <= nxt_statSnap;
        end
    end

    // ----------------------------------------
    // read port
    // ----------------------------------------
    logic [7:0] rdData_ff;
    logic [7:0] nxt_rdData;
    logic       rdValid_ff;
    logic       nxt_rdValid;

    always_comb
    begin
        // a read in the same cycle as a write returns the old contents
        nxt_rdData  = rdData_ff;
        nxt_rdValid = regRdEn;
        if (regRdEn)
        begin
            case (regAddr)
                `PLLRH_ADDR_REFCTL:  nxt_rdData = 8'(refCtl_ff);
                `PLLRH_ADDR_ZDCTL:   nxt_rdData = 8'(zdCtl_ff);
                `PLLRH_ADDR_PLLSTAT: nxt_rdData = statSnap_ff;
                default:             nxt_rdData = `PLLRH_ZERO_BYTE;
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            rdData_ff  <= `PLLRH_ZERO_BYTE;
            rdValid_ff <= 1'b0;
        end
        else
        begin
            rdData_ff  <= nxt_rdData;
            rdValid_ff <= nxt_rdValid;
        end
    end

    assign regRdData  = rdData_ff;
    assign regRdValid = rdValid_ff;

    // ----------------------------------------
    // control outputs
    // ----------------------------------------
    assign statusPinOut = refCtl_ff.statusEepromSel ? statusEeprom : statusSelected; // R1
    assign xtalAmpEn    = refCtl_ff.xtalAmpEn;    // R2
    assign refDoublerEn = refCtl_ff.refDoublerEn; // R3

    pllrh_hold_t holdCtl;

    pllrh_hold_ctrl uHold
    (
        .refCtl           (refCtl_ff),
        .lockIndicatorPin (lockIndicatorPin),
        .outputAlignPin   (outputAlignPin),
        .holdCtl          (holdCtl)
    );

    assign holdoverInternalEn    = holdCtl.internalHoldEn;
    assign holdoverExternalEn    = holdCtl.externalHoldEn;
    assign holdoverExternalEntry = holdCtl.externalEntry;
    assign holdoverLockQualified = holdCtl.lockQualified;

    assign zeroDelayInternalEn = zdCtl_ff.zeroDelayEn & ~zdCtl_ff.extZeroDelaySel; // R10
    assign zeroDelayExternalEn = zdCtl_ff.zeroDelayEn & zdCtl_ff.extZeroDelaySel;  // R10
    // feedback choice only matters in external mode but stays visible for debug
    assign zeroDelayFbSel    = zdCtl_ff.fbDividerSel;           // R9
    assign zeroDelayFbOneHot = decodeFb(zdCtl_ff.fbDividerSel); // R9

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    ref_reset_a: assert property ($fell(rst) |-> refCtl_ff == pllrh_refctl_t'(`PLLRH_REFCTL_RST)) // R11
        else $error("reference control not at reset value");
    status_pin_a: assert property (statusPinOut == (refCtl_ff.statusEepromSel ? statusEeprom : statusSelected)) // R1
        else $error("status pin source wrong");
    stat_freeze_a: assert property (refCtl_ff.freezeStatus |=> $stable(statSnap_ff)) // R4
        else $error("status snapshot moved while frozen");
    stat_update_a: assert property (!refCtl_ff.freezeStatus |=> statSnap_ff == ($past(pllStatusLive) & `PLLRH_STAT_MASK)) // R4
        else $error("status snapshot not updated");
    lock_const_a: assert property (!refCtl_ff.lockCmpEn |-> holdoverLockQualified) // R5
        else $error("lock qualifier not high with comparator off");
    lock_follow_a: assert property (refCtl_ff.lockCmpEn |-> holdoverLockQualified == lockIndicatorPin) // R6
        else $error("lock qualifier not following pin");
    hold_exclusive_a: assert property (!(holdoverInternalEn && holdoverExternalEn)) // R7
        else $error("both holdover sources enabled");
    hold_off_a: assert property (!refCtl_ff.holdoverEn |-> !holdoverInternalEn && !holdoverExternalEntry) // R8
        else $error("holdover active while disabled");
    fb_onehot_a: assert property (zeroDelayFbOneHot[zeroDelayFbSel] && $onehot(zeroDelayFbOneHot)) // R9
        else $error("feedback divider decode wrong");
    zd_off_a: assert property (!zdCtl_ff.zeroDelayEn |-> !zeroDelayInternalEn && !zeroDelayExternalEn) // R10
        else $error("zero delay active while disabled");
    zd_write_a: assert property (regWrEn && regAddr == `PLLRH_ADDR_ZDCTL // R11
                                 |=> zdCtl_ff == ($past(regWrData) & `PLLRH_ZDCTL_MASK))
        else $error("zero delay write not masked");
    rd_latency_a: assert property (regRdEn && regAddr == `PLLRH_ADDR_REFCTL // R11
                                   |=> regRdValid && regRdData == $past(refCtl_ff))
        else $error("read answer wrong");
    ref_write_a: assert property (regWrEn && regAddr == `PLLRH_ADDR_REFCTL // R11
                                  |=> refCtl_ff == ($past(regWrData) & `PLLRH_REFCTL_MASK))
        else $error("reference control write not masked");
    amp_default_a: assert property ($fell(rst) |-> !xtalAmpEn && !refDoublerEn) // R2 R3
        else $error("amplifier or doubler not off after reset");
    ext_entry_a: assert property (holdoverExternalEntry == (holdoverExternalEn && outputAlignPin)) // R7
        else $error("external holdover entry not following pin");
    stat_read_a: assert property (regRdEn && regAddr == `PLLRH_ADDR_PLLSTAT // R4
                                  |=> regRdData == $past(statSnap_ff))
        else $error("status readback wrong");
    unmapped_read_a: assert property (regRdEn && regAddr != `PLLRH_ADDR_REFCTL // R11
                                      && regAddr != `PLLRH_ADDR_ZDCTL && regAddr != `PLLRH_ADDR_PLLSTAT
                                      |=> regRdData == `PLLRH_ZERO_BYTE)
        else $error("unmapped read not zero");

endmodule // pllrh_config

`default_nettype wire

// ### verilog/pllrh_regs.svh
`ifndef PLLRH_REGS_SVH
`define PLLRH_REGS_SVH

// ----------------------------------------
// register addresses
// ----------------------------------------
`define PLLRH_ADDR_W        10
`define PLLRH_ADDR_REFCTL   10'h01D
`define PLLRH_ADDR_ZDCTL    10'h01E
`define PLLRH_ADDR_PLLSTAT  10'h01F

// ----------------------------------------
// reset values and writable masks
// ----------------------------------------
`define PLLRH_REFCTL_RST    8'h80
`define PLLRH_REFCTL_MASK   8'hFB
`define PLLRH_ZDCTL_RST     8'h00
`define PLLRH_ZDCTL_MASK    8'h1E
`define PLLRH_STAT_RST      8'h00
`define PLLRH_STAT_MASK     8'h7F
`define PLLRH_ZERO_BYTE     8'h00

`endif

// ### verilog/pllrh_pkg.sv
`default_nettype none

package pllrh_pkg;

    // field order matches register bit order, msb first
    typedef struct packed {
        logic statusEepromSel;
        logic xtalAmpEn;
        logic refDoublerEn;
        logic freezeStatus;
        logic lockCmpEn;
        logic unusedBit2;
        logic extHoldoverSel;
        logic holdoverEn;
    } pllrh_refctl_t;

    typedef struct packed {
        logic [2:0] unusedHigh;
        logic [1:0] fbDividerSel;
        logic       extZeroDelaySel;
        logic       zeroDelayEn;
        logic       unusedBit0;
    } pllrh_zdctl_t;

    typedef struct packed {
        logic internalHoldEn;
        logic externalHoldEn;
        logic externalEntry;
        logic lockQualified;
    } pllrh_hold_t;

endpackage

`default_nettype wire

// ### verilog/pllrh_hold_ctrl.sv
`default_nettype none

module pllrh_hold_ctrl
    import pllrh_pkg::*;
(
    input  wire pllrh_refctl_t refCtl,
    input  wire logic          lockIndicatorPin,
    input  wire logic          outputAlignPin,
    output pllrh_hold_t        holdCtl
);

    // ----------------------------------------
    // holdover routing
    // ----------------------------------------
    // pure routing of config bits; the holdover state machine sits outside
    always_comb
    begin
        // comparator off: pin reads as a constant high to the controller
        holdCtl.lockQualified  = refCtl.lockCmpEn ? lockIndicatorPin : 1'b1; // R5 R6
        holdCtl.internalHoldEn = refCtl.holdoverEn & ~refCtl.extHoldoverSel; // R7 R8
        holdCtl.externalHoldEn = refCtl.holdoverEn & refCtl.extHoldoverSel;  // R7 R8
        holdCtl.externalEntry  = holdCtl.externalHoldEn & outputAlignPin;   // R7
    end

endmodule // pllrh_hold_ctrl

`default_nettype wire

// ### sim/pll_ref_holdover_config_tb_top.sv
`include "pllrh_regs.svh"
`default_nettype none

module pll_ref_holdover_config_tb_top
    import pllrh_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // stimulus and observed signals
    // ----------------------------------------
    logic       clk_sys = 1'b0;
    logic       rst = 1'b1;
    logic [9:0] regAddr;
    logic [7:0] regWrData;
    logic [7:0] regRdData;
    logic [7:0] pllStatusLive;
    logic       regWrEn, regRdEn, regRdValid, statusEeprom, statusSelected, statusPinOut;
    logic       xtalAmpEn, refDoublerEn, lockIndicatorPin, outputAlignPin;
    logic       holdoverInternalEn, holdoverExternalEn, holdoverExternalEntry, holdoverLockQualified;
    logic       zeroDelayInternalEn, zeroDelayExternalEn;
    logic [1:0] zeroDelayFbSel;
    logic [3:0] zeroDelayFbOneHot;
    int         fail_count = 0;
    int         samples_checked = 0;
    int         refM = 8'h80;
    int         zdM = 0;

    always #12.5 clk_sys = ~clk_sys;

    pllrh_config DUT (
        .clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
        .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid), .statusEeprom(statusEeprom),
        .statusSelected(statusSelected), .statusPinOut(statusPinOut), .xtalAmpEn(xtalAmpEn),
        .refDoublerEn(refDoublerEn), .pllStatusLive(pllStatusLive), .lockIndicatorPin(lockIndicatorPin),
        .outputAlignPin(outputAlignPin), .holdoverInternalEn(holdoverInternalEn),
        .holdoverExternalEn(holdoverExternalEn), .holdoverExternalEntry(holdoverExternalEntry),
        .holdoverLockQualified(holdoverLockQualified), .zeroDelayInternalEn(zeroDelayInternalEn),
        .zeroDelayExternalEn(zeroDelayExternalEn), .zeroDelayFbSel(zeroDelayFbSel),
        .zeroDelayFbOneHot(zeroDelayFbOneHot)
    );

    // ----------------------------------------
    // checking and bus tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error %s expected %0h seen %0h", nm, exp, got);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // strobes rise at a falling edge and drop one cycle later, so each is seen on exactly one rising edge
    // an idle cycle closes each call so the next call never re-raises a strobe in the same time step
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(negedge clk_sys);
        regWrEn = 1'b0;
        if (a == 10'h01D) refM = d & 8'hFB;
        if (a == 10'h01E) zdM = d & 8'h1E;
        @(negedge clk_sys);
    endtask

    task automatic rd(input logic [9:0] a, input logic [7:0] exp);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge clk_sys);
        regRdEn = 1'b0;
        chk("rdValid", 8'h01, 8'(regRdValid));
        chk("rdData", exp, regRdData);
        @(negedge clk_sys);
        chk("rdValidEnd", 8'h00, 8'(regRdValid));
    endtask

    task automatic checkOuts;
        logic [7:0] r;
        logic [7:0] z;
        r = 8'(refM);
        z = 8'(zdM);
        chk("statusPin", 8'(r[7] ? statusEeprom : statusSelected), 8'(statusPinOut));
        chk("xtalAmp", 8'(r[6]), 8'(xtalAmpEn));
        chk("doubler", 8'(r[5]), 8'(refDoublerEn));
        chk("lockQual", 8'(r[3] ? lockIndicatorPin : 1'b1), 8'(holdoverLockQualified));
        chk("holdover", 8'({r[0] & ~r[1], r[0] & r[1], r[0] & r[1] & outputAlignPin}),
            8'({holdoverInternalEn, holdoverExternalEn, holdoverExternalEntry}));
        chk("zeroDelay", {z[4:3], z[1] & ~z[2], z[1] & z[2], 4'(4'h1 << z[4:3])},
            {zeroDelayFbSel, zeroDelayInternalEn, zeroDelayExternalEn, zeroDelayFbOneHot});
    endtask

    // ----------------------------------------
    // watchdog and main sequence
    // ----------------------------------------
    initial
    begin
        repeat (6000) @(posedge clk_sys);
        fail_count++;
        print_verdict();
    end

    initial
    begin
        {regAddr, regWrData, regWrEn, regRdEn, pllStatusLive} = '0;
        {statusEeprom, statusSelected, lockIndicatorPin, outputAlignPin} = 4'h5;
        void'($urandom(16762));
        repeat (12) @(negedge clk_sys);
        rst = 1'b0;
        rd(10'h01D, 8'h80);
        rd(10'h01E, 8'h00);
        checkOuts();
        rd(10'h3FF, 8'h00);
        for (int c = 0; c < 4; c++)
        begin
            wr(10'h01E, 8'(c << 3) | 8'h06);
            checkOuts();
        end
        // random sweep writes 200 random values to each register against random pins
        repeat (200)
        begin
            {statusEeprom, statusSelected, lockIndicatorPin, outputAlignPin} = 4'($urandom);
            pllStatusLive = 8'($urandom);
            wr(10'h01D, 8'($urandom));
            wr(10'h01E, 8'($urandom));
            checkOuts();
            rd(10'h01D, 8'(refM));
            rd(10'h01E, 8'(zdM));
        end
        wr(10'h01D, 8'h00);
        pllStatusLive = 8'hD5;
        repeat (2) @(negedge clk_sys);
        rd(10'h01F, 8'h55);
        wr(10'h01D, 8'h10);
        pllStatusLive = 8'h2A;
        repeat (3) @(negedge clk_sys);
        rd(10'h01F, 8'h55);
        wr(10'h01D, 8'h00);
        @(negedge clk_sys);
        rd(10'h01F, 8'h2A);
        wr(10'h01E, 8'hFF);
        checkOuts();
        rst = 1'b1;
        @(negedge clk_sys);
        rst = 1'b0;
        refM = 8'h80;
        zdM = 0;
        rd(10'h01D, 8'h80);
        rd(10'h01E, 8'h00);
        print_verdict();
    end

endmodule // pll_ref_holdover_config_tb_top

`default_nettype wire
